//--- core/dbt_params.svh
/*
 * Offsets, field positions and reset values of the dual bus transceiver.
 * Assumes inclusion by bare name from any file of the block.
 */
`ifndef DBT_PARAMS_SVH
`define DBT_PARAMS_SVH

// ==========================================
// bus width and log
// ==========================================
`define DBT_BUS_W       8
`define DBT_LOG_DEPTH   32
`define DBT_LOG_W       9

// ==========================================
// register offsets (byte addresses)
// ==========================================
`define DBT_OFF_W       8
`define DBT_OFF_CTRL    8'h00
`define DBT_OFF_STATUS  8'h04
`define DBT_OFF_LOG     8'h08

// ==========================================
// control word
// ==========================================
`define DBT_CTRL_W      6
`define DBT_CTRL_RST    6'h04

// ==========================================
// status and log fields
// ==========================================
`define DBT_ST_ASTORE   0
`define DBT_ST_BSTORE   8
`define DBT_ST_EMPTY    16
`define DBT_ST_FULL     17
`define DBT_ST_OVF      18
`define DBT_LOG_VALID   31

`endif

//--- core/dbt_pkg.sv
/*
 * Types of the dual bus transceiver.
 * Assumes dbt_params.svh for widths.
 */
`include "dbt_params.svh"
package dbt_pkg;

	typedef enum logic {
		DBT_SIDE_A,
		DBT_SIDE_B
	} dbt_side_e;

	// field order puts the override flag in bit 0
	typedef struct packed {
		logic log_en;
		logic a_side_source_select;
		logic b_side_source_select;
		logic b_to_a_drive_enable_n;
		logic a_to_b_drive_enable;
		logic ovr;
	} dbt_ctrl_s;

	typedef struct packed {
		dbt_side_e                side;
		logic [`DBT_BUS_W-1:0]    data;
	} dbt_log_s;

endpackage : dbt_pkg

//--- core/dbt_store.sv
/*
 * One storage register with its capture-edge detector.
 * Assumes the capture clock is a level synchronous to i_clk.
 */
`timescale 1ns/1ps
`include "dbt_params.svh"
module dbt_store (
	input  wire logic                  i_clk,
	input  wire logic                  i_rst,
	input  wire logic                  i_cap_clk,
	input  wire logic [`DBT_BUS_W-1:0] i_data,
	output logic      [`DBT_BUS_W-1:0] o_q,
	output logic                       o_cap
);
	logic                  prev_r;
	logic [`DBT_BUS_W-1:0] q_r;

	assign o_cap = i_cap_clk & ~prev_r;
	assign o_q   = q_r;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			prev_r <= 1'b0;
		end else begin
			prev_r <= i_cap_clk;
		end
	end

	// no reset: content is undefined until the first capture
	always_ff @(posedge i_clk) begin
		if (o_cap) begin
			q_r <= i_data;
		end
	end
endmodule : dbt_store

//--- core/dbt_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and synchronous active-high reset.
 */
`timescale 1ns/1ps
module dbt_fifo #(
	parameter int W = 9,
	parameter int D = 32
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic         i_in_valid,
	output logic              o_in_ready,
	input  wire logic [W-1:0] i_in_data,
	output logic              o_out_valid,
	input  wire logic         i_out_ready,
	output logic      [W-1:0] o_out_data
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem [D];
	logic [AW:0]  wr_r;
	logic [AW:0]  rd_r;
	logic         push;
	logic         pop;

	assign o_out_valid = (wr_r != rd_r);
	assign o_in_ready  = (wr_r[AW-1:0] != rd_r[AW-1:0]) || (wr_r[AW] == rd_r[AW]);
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;
	assign o_out_data  = mem[rd_r[AW-1:0]];

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_r[AW-1:0]] <= i_in_data;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wr_r <= '0;
			rd_r <= '0;
		end else begin
			wr_r <= wr_r + (AW+1)'(push);
			rd_r <= rd_r + (AW+1)'(pop);
		end
	end
endmodule : dbt_fifo

//--- core/dbt_transceiver.sv
/*
 * Dual bus transceiver with one storage register per direction, a capture
 * log FIFO and an AHB-Lite register slave.
 * Assumes all pin inputs synchronous to i_clk; the bench resolves each
 * bus wire from the output enables. Capture clocks are sampled levels.
 */
// Summary of operation
// RL1 - each rising capture clock edge loads its bus into its storage register.
// RL2 - capture is never gated by selects or drive enables, even when isolated.
// RL3 - a low source select passes live data, a high one passes stored data.
// RL4 - a-to-b enable high with b select low drives b from live a.
// RL5 - a-to-b enable high with b select high drives b from the a register.
// RL6 - b-to-a enable low with a select low drives a from live b.
// RL7 - b-to-a enable low with a select high drives a from the b register.
// RL8 - both enables active and both selects high drive both buses from the opposite registers.
// RL9 - a-to-b enable low and b-to-a enable high leave both buses undriven.
// RL10 - with only a-to-b driving, both clocks load the a value into both registers.
// RL11 - with only b-to-a driving, both clocks load the b value into both registers.
// RL12 - live selects with both enables active make each output echo its input as a hold loop.
// RL13 - in that loop each bus takes the other bus's value of the cycle before once all other sources float.
// RL14 - with select low the far side may raise both capture clocks together.
// RL15 - with select high the far side staggers the two capture clocks.
// RL16 - the storage registers have no reset and are undefined until first captured.
// RL17 - the far side enables a direction only when nothing else drives that bus.
`timescale 1ns/1ps
`include "dbt_params.svh"
module dbt_transceiver #(
	parameter int LOG_DEPTH = `DBT_LOG_DEPTH
) (
	input  wire logic                  i_clk,
	input  wire logic                  i_rst,
	// a bus pins
	input  wire logic [`DBT_BUS_W-1:0] i_a_bus_lines,
	output logic      [`DBT_BUS_W-1:0] o_a_bus_lines,
	output logic                       o_a_bus_lines_oe,
	// b bus pins
	input  wire logic [`DBT_BUS_W-1:0] i_b_bus_lines,
	output logic      [`DBT_BUS_W-1:0] o_b_bus_lines,
	output logic                       o_b_bus_lines_oe,
	// control pins
	input  wire logic                  i_a_to_b_drive_enable,
	input  wire logic                  i_b_to_a_drive_enable_n,
	input  wire logic                  i_a_capture_clock,
	input  wire logic                  i_b_capture_clock,
	input  wire logic                  i_b_side_source_select,
	input  wire logic                  i_a_side_source_select,
	output logic                       o_log_ready,
	// ahb-lite slave
	input  wire logic                  i_hsel,
	input  wire logic [31:0]           i_haddr,
	input  wire logic [1:0]            i_htrans,
	input  wire logic                  i_hwrite,
	input  wire logic [2:0]            i_hsize,
	input  wire logic [31:0]           i_hwdata,
	input  wire logic                  i_hready,
	output logic                       o_hreadyout,
	output logic [31:0]                o_hrdata,
	output logic                       o_hresp
);

	// ==========================================
	// declarations
	// ==========================================
	dbt_pkg::dbt_ctrl_s    ctrl_r;
	dbt_pkg::dbt_ctrl_s    ctl;
	dbt_pkg::dbt_ctrl_s    ctrl_view;
	dbt_pkg::dbt_log_s     log_in;
	dbt_pkg::dbt_log_s     log_out;
	logic [`DBT_BUS_W-1:0] a_q;
	logic [`DBT_BUS_W-1:0] b_q;
	logic                  a_cap;
	logic                  b_cap;
	logic [`DBT_BUS_W-1:0] a_out_r;
	logic [`DBT_BUS_W-1:0] b_out_r;
	logic [`DBT_BUS_W-1:0] a_out_nxt;
	logic [`DBT_BUS_W-1:0] b_out_nxt;
	logic                  a_oe_r;
	logic                  b_oe_r;
	logic                  b_wait_r;
	logic                  b_wait_nxt;
	logic                  ovf_r;
	logic                  ovf_nxt;
	logic                  log_ready_r;
	logic                  log_valid;
	logic                  log_in_ready;
	logic                  log_out_valid;
	logic                  log_pop;
	logic                  lose;
	logic                  acc;
	logic                  rd_acc;
	logic                  wr_acc;
	logic                  wr_pend_r;
	logic [`DBT_OFF_W-1:0] wr_addr_r;
	logic [`DBT_OFF_W-1:0] rd_addr;
	logic                  wr_ctrl;
	logic                  ovf_clr;
	logic [31:0]           rd_data;
	logic [31:0]           hrdata_r;
	logic                  hreadyout_r;
	logic                  hresp_r;

	// ==========================================
	// storage registers
	// ==========================================
	// capture samples the resolved pin level, so a bus this block drives
	// is stored as the driven value [RL10] [RL11]
	dbt_store u_a_store (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_cap_clk (i_a_capture_clock),
		.i_data    (i_a_bus_lines),
		.o_q       (a_q),
		.o_cap     (a_cap)
	); // [RL1] [RL2] [RL16]

	dbt_store u_b_store (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_cap_clk (i_b_capture_clock),
		.i_data    (i_b_bus_lines),
		.o_q       (b_q),
		.o_cap     (b_cap)
	); // [RL1] [RL2] [RL16]

	// ==========================================
	// control source and data paths
	// ==========================================
	// software may take the pins over for bring-up; the pins rule by default
	assign ctl = ctrl_r.ovr ? ctrl_r : dbt_pkg::dbt_ctrl_s'({
		ctrl_r.log_en,
		i_a_side_source_select,
		i_b_side_source_select,
		i_b_to_a_drive_enable_n,
		i_a_to_b_drive_enable,
		1'b0});

	// live data feeds straight back when both directions drive, which is
	// the hold loop; each bus takes the other's level of the cycle before once all other sources float [RL12] [RL13]
	assign b_out_nxt = ctl.b_side_source_select ? a_q : i_a_bus_lines; // [RL3] [RL4] [RL5]
	assign a_out_nxt = ctl.a_side_source_select ? b_q : i_b_bus_lines; // [RL3] [RL6] [RL7]

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			a_out_r <= '0;
			b_out_r <= '0;
			a_oe_r  <= 1'b0;
			b_oe_r  <= 1'b0;
		end else begin
			a_out_r <= a_out_nxt;
			b_out_r <= b_out_nxt;
			a_oe_r  <= ~ctl.b_to_a_drive_enable_n; // [RL6] [RL8] [RL9]
			b_oe_r  <= ctl.a_to_b_drive_enable;    // [RL4] [RL8] [RL9]
		end
	end

	assign o_a_bus_lines    = a_out_r;
	assign o_b_bus_lines    = b_out_r;
	assign o_a_bus_lines_oe = a_oe_r;
	assign o_b_bus_lines_oe = b_oe_r;

	// ==========================================
	// capture log
	// ==========================================
	// one push per cycle: a wins a tie and b waits one cycle; a b capture
	// that arrives with an a capture while one still waits overwrites it and counts as lost
	assign log_valid   = ctl.log_en & (a_cap | b_cap | b_wait_r);
	assign log_in.side = a_cap ? dbt_pkg::DBT_SIDE_A : dbt_pkg::DBT_SIDE_B;
	assign log_in.data = a_cap ? i_a_bus_lines : (b_cap ? i_b_bus_lines : b_q);
	assign b_wait_nxt  = ctl.log_en & a_cap & (b_cap | b_wait_r);
	assign lose        = (a_cap & b_cap & b_wait_r & ctl.log_en) | (log_valid & ~log_in_ready);

	// a full log never stalls capture; it only drops the entry
	dbt_fifo #(
		.W (`DBT_LOG_W),
		.D (LOG_DEPTH)
	) u_log (
		.i_clk       (i_clk),
		.i_rst       (i_rst),
		.i_in_valid  (log_valid),
		.o_in_ready  (log_in_ready),
		.i_in_data   (log_in),
		.o_out_valid (log_out_valid),
		.i_out_ready (log_pop),
		.o_out_data  (log_out)
	);

	// set wins over a clear in the same cycle
	assign ovf_nxt = lose | (ovf_r & ~ovf_clr);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			b_wait_r    <= 1'b0;
			ovf_r       <= 1'b0;
			log_ready_r <= 1'b0;
		end else begin
			b_wait_r    <= b_wait_nxt;
			ovf_r       <= ovf_nxt;
			log_ready_r <= log_in_ready;
		end
	end

	assign o_log_ready = log_ready_r;

	// ==========================================
	// ahb-lite slave
	// ==========================================
	// zero wait states; only the low offset byte is decoded, so the map aliases
	assign acc     = i_hsel & i_htrans[1] & i_hready;
	assign rd_acc  = acc & ~i_hwrite;
	assign wr_acc  = acc & i_hwrite;
	assign rd_addr = i_haddr[`DBT_OFF_W-1:0];
	assign wr_ctrl = wr_pend_r & (wr_addr_r == `DBT_OFF_CTRL);
	assign ovf_clr = wr_pend_r & (wr_addr_r == `DBT_OFF_STATUS) & i_hwdata[`DBT_ST_OVF];
	assign log_pop = rd_acc & (rd_addr == `DBT_OFF_LOG) & log_out_valid;

	// a read right behind a control write sees the new value
	assign ctrl_view = wr_ctrl ? dbt_pkg::dbt_ctrl_s'(i_hwdata[`DBT_CTRL_W-1:0]) : ctrl_r;

	always_comb begin
		rd_data = 32'h0000_0000;
		if (rd_addr == `DBT_OFF_CTRL) begin
			rd_data[`DBT_CTRL_W-1:0] = ctrl_view;
		end else if (rd_addr == `DBT_OFF_STATUS) begin
			rd_data[`DBT_ST_ASTORE +: `DBT_BUS_W] = a_q;
			rd_data[`DBT_ST_BSTORE +: `DBT_BUS_W] = b_q;
			rd_data[`DBT_ST_EMPTY]                = ~log_out_valid;
			rd_data[`DBT_ST_FULL]                 = ~log_in_ready;
			rd_data[`DBT_ST_OVF]                  = ovf_r;
		end else if (rd_addr == `DBT_OFF_LOG) begin
			rd_data[`DBT_LOG_W-1:0]   = log_out_valid ? log_out : '0;
			rd_data[`DBT_LOG_VALID]   = log_out_valid;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ctrl_r <= dbt_pkg::dbt_ctrl_s'(`DBT_CTRL_RST);
		end else if (wr_ctrl) begin
			ctrl_r <= dbt_pkg::dbt_ctrl_s'(i_hwdata[`DBT_CTRL_W-1:0]);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= '0;
		end else begin
			wr_pend_r <= wr_acc;
			wr_addr_r <= rd_addr;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			hrdata_r    <= 32'h0000_0000;
			hreadyout_r <= 1'b0;
			hresp_r     <= 1'b0;
		end else begin
			hreadyout_r <= 1'b1;
			hresp_r     <= 1'b0;
			if (rd_acc) begin
				hrdata_r <= rd_data;
			end
		end
	end

	assign o_hrdata    = hrdata_r;
	assign o_hreadyout = hreadyout_r;
	assign o_hresp     = hresp_r;

	// ==========================================
	// assertions
	// ==========================================
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	property p_store_a;
		a_cap |=> (a_q == $past(i_a_bus_lines));
	endproperty
	a_store_a: assert property (p_store_a) else $error("a register missed its capture"); // [RL1]

	property p_store_b_isolated;
		(b_cap && !ctl.a_to_b_drive_enable && ctl.b_to_a_drive_enable_n)
			|=> (b_q == $past(i_b_bus_lines)) && !o_b_bus_lines_oe;
	endproperty
	a_store_b_isolated: assert property (p_store_b_isolated) else $error("b capture gated while isolated"); // [RL2]

	property p_live_ab;
		(ctl.a_to_b_drive_enable && !ctl.b_side_source_select)
			|=> o_b_bus_lines_oe && (o_b_bus_lines == $past(i_a_bus_lines));
	endproperty
	a_live_ab: assert property (p_live_ab) else $error("b bus not fed from live a"); // [RL4]

	property p_stored_ab;
		(ctl.a_to_b_drive_enable && ctl.b_side_source_select)
			|=> o_b_bus_lines_oe && (o_b_bus_lines == $past(a_q));
	endproperty
	a_stored_ab: assert property (p_stored_ab) else $error("b bus not fed from a register"); // [RL5]

	property p_live_ba;
		(!ctl.b_to_a_drive_enable_n && !ctl.a_side_source_select)
			|=> o_a_bus_lines_oe && (o_a_bus_lines == $past(i_b_bus_lines));
	endproperty
	a_live_ba: assert property (p_live_ba) else $error("a bus not fed from live b"); // [RL6]

	property p_stored_ba;
		(!ctl.b_to_a_drive_enable_n && ctl.a_side_source_select)
			|=> o_a_bus_lines_oe && (o_a_bus_lines == $past(b_q));
	endproperty
	a_stored_ba: assert property (p_stored_ba) else $error("a bus not fed from b register"); // [RL7]

	property p_both_stored;
		(ctl.a_to_b_drive_enable && !ctl.b_to_a_drive_enable_n
			&& ctl.a_side_source_select && ctl.b_side_source_select)
			|=> o_a_bus_lines_oe && o_b_bus_lines_oe
			&& (o_a_bus_lines == $past(b_q)) && (o_b_bus_lines == $past(a_q));
	endproperty
	a_both_stored: assert property (p_both_stored) else $error("dual stored transfer wrong"); // [RL8]

	property p_isolate;
		(!ctl.a_to_b_drive_enable && ctl.b_to_a_drive_enable_n) [*2]
			|-> !o_a_bus_lines_oe && !o_b_bus_lines_oe;
	endproperty
	a_isolate: assert property (p_isolate) else $error("bus driven while isolated"); // [RL9]

	property p_hold_loop;
		(ctl.a_to_b_drive_enable && !ctl.b_to_a_drive_enable_n
			&& !ctl.a_side_source_select && !ctl.b_side_source_select)
			|=> (o_a_bus_lines == $past(i_b_bus_lines)) && (o_b_bus_lines == $past(i_a_bus_lines))
			&& o_a_bus_lines_oe && o_b_bus_lines_oe;
	endproperty
	a_hold_loop: assert property (p_hold_loop) else $error("hold loop not formed"); // [RL12]

	property p_ovf_set_wins;
		lose |=> ovf_r;
	endproperty
	a_ovf_set_wins: assert property (p_ovf_set_wins) else $error("lost log entry not flagged");

	c_isolate_store: cover property ((!ctl.a_to_b_drive_enable && ctl.b_to_a_drive_enable_n) && a_cap && b_cap);
	c_dual_stored: cover property (o_a_bus_lines_oe && o_b_bus_lines_oe && ctl.a_side_source_select);
	c_log_full: cover property (log_valid && !log_in_ready);
	c_log_pop: cover property (log_pop ##3 rd_acc);

endmodule : dbt_transceiver

//--- tb/dbt_bus_peer.sv
/*
 * Far-side logic on the two parallel buses, with the wire resolution of each bus.
 * Assumes the bench sets its drive requests just after rising clock edges.
 */
`timescale 1ns/1ps
`include "dbt_params.svh"
module dbt_bus_peer (
	input  wire logic                  i_clk,
	input  wire logic [`DBT_BUS_W-1:0] i_dev_a,
	input  wire logic                  i_dev_a_oe,
	input  wire logic [`DBT_BUS_W-1:0] i_dev_b,
	input  wire logic                  i_dev_b_oe,
	input  wire logic                  i_drv_a,
	input  wire logic [`DBT_BUS_W-1:0] i_val_a,
	input  wire logic                  i_drv_b,
	input  wire logic [`DBT_BUS_W-1:0] i_val_b,
	output logic      [`DBT_BUS_W-1:0] o_a_wire,
	output logic      [`DBT_BUS_W-1:0] o_b_wire
);
	logic [`DBT_BUS_W-1:0] a_last_r = '0;
	logic [`DBT_BUS_W-1:0] b_last_r = '0;

	// two drivers at once give an unknown on that wire, which fails any check that samples it
	assign o_a_wire = (i_dev_a_oe & i_drv_a) ? 'x : i_dev_a_oe ? i_dev_a : i_drv_a ? i_val_a : ~a_last_r;
	assign o_b_wire = (i_dev_b_oe & i_drv_b) ? 'x : i_dev_b_oe ? i_dev_b : i_drv_b ? i_val_b : ~b_last_r;

	// no pull-ups: an undriven bus toggles each cycle instead of keeping its value
	always @(posedge i_clk) begin
		a_last_r <= o_a_wire;
		b_last_r <= o_b_wire;
	end
endmodule : dbt_bus_peer

//--- tb/testbench.sv
/*
 * Self-checking bench of the dual bus transceiver: pins, storage, log and registers.
 * Assumes the design files and dbt_params.svh on the include path.
 */
`timescale 1ns/1ps
`include "dbt_params.svh"
module testbench;
	localparam int DEPTH = `DBT_LOG_DEPTH;
	// ==========================================
	// signals
	// ==========================================
	logic        i_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic [7:0]  a_w, b_w, o_a, o_b, p_a, p_b, x, y;
	logic        oe_a, oe_b, drv_a, drv_b, log_rdy;
	logic        a2b, b2a_n, bsel, asel, acap, bcap;
	logic        hsel, hwrite, hrdy, hresp;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, d;
	int          err_total, compares, seed, k;

	always #5 i_clk = ~i_clk;

	// ==========================================
	// instances
	// ==========================================
	dbt_transceiver #(.LOG_DEPTH(DEPTH)) dbt_transceiver_inst (.i_clk(i_clk), .i_rst(i_rst),
		.i_a_bus_lines(a_w), .o_a_bus_lines(o_a), .o_a_bus_lines_oe(oe_a),
		.i_b_bus_lines(b_w), .o_b_bus_lines(o_b), .o_b_bus_lines_oe(oe_b),
		.i_a_to_b_drive_enable(a2b), .i_b_to_a_drive_enable_n(b2a_n),
		.i_a_capture_clock(acap), .i_b_capture_clock(bcap),
		.i_b_side_source_select(bsel), .i_a_side_source_select(asel), .o_log_ready(log_rdy),
		.i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010),
		.i_hwdata(hwdata), .i_hready(hrdy), .o_hreadyout(hrdy), .o_hrdata(hrdata), .o_hresp(hresp));

	dbt_bus_peer dbt_bus_peer_inst (.i_clk(i_clk), .i_dev_a(o_a), .i_dev_a_oe(oe_a),
		.i_dev_b(o_b), .i_dev_b_oe(oe_b), .i_drv_a(drv_a), .i_val_a(p_a),
		.i_drv_b(drv_b), .i_val_b(p_b), .o_a_wire(a_w), .o_b_wire(b_w));

	// ==========================================
	// tasks
	// ==========================================
	task complete_run;
		if (err_total == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run

	task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t %s: seen %h expected %h", $time, what, seen, exp);
		end
	endtask : chk

	// address phase held until hready, then data phase until hready again
	task ahb(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
		@(posedge i_clk);
		hsel   <= 1'b1;
		haddr  <= {24'h0, adr};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge i_clk); while (hrdy !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge i_clk); while (hrdy !== 1'b1);
		d = hrdata;
		chk({31'h0, hresp}, 32'h0, "bus response");
	endtask : ahb

	// pins first, far side one edge later, so the two never drive a bus together
	task mode(input logic [3:0] pins, input logic da, input logic [7:0] va, input logic db, input logic [7:0] vb);
		@(posedge i_clk);
		{a2b, b2a_n, bsel, asel} <= pins;
		@(posedge i_clk);
		drv_a <= da;
		p_a   <= va;
		drv_b <= db;
		p_b   <= vb;
		repeat (3) @(posedge i_clk);
		#1;
	endtask : mode

	task cap(input logic ac, input logic bc);
		@(posedge i_clk);
		acap <= ac;
		bcap <= bc & ~(asel | bsel); // together only with live data selected
		@(posedge i_clk);
		acap <= 1'b0;
		bcap <= 1'b0;
		@(posedge i_clk);
		// two edges apart: the registered b output must show the new a register first
		bcap <= bc & (asel | bsel);
		@(posedge i_clk);
		bcap <= 1'b0;
		repeat (3) @(posedge i_clk);
		#1;
	endtask : cap

	// ==========================================
	// sequence
	// ==========================================
	initial begin
		repeat (20000) @(posedge i_clk);
		err_total++;
		complete_run;
	end

	initial begin
		seed = 22740;
		err_total = 0;
		compares = 0;
		{a2b, b2a_n, bsel, asel} = 4'b0100;
		{acap, bcap, drv_a, drv_b, hsel, hwrite} = 6'h00;
		{p_a, p_b, htrans} = 18'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		repeat (10) @(posedge i_clk);
		i_rst <= 1'b0;
		ahb(1'b0, `DBT_OFF_CTRL, 32'h0);
		chk(d, 32'h4, "control after reset");
		for (k = 0; k < 6; k++) begin
			x = (k == 0) ? 8'h00 : 8'($random(seed));
			y = (k == 0) ? 8'hFF : 8'($random(seed));
			mode(4'b0100, 1'b1, x, 1'b1, y);
			cap(1'b1, 1'b1);
			chk({oe_a, oe_b}, 32'h0, "isolated outputs");
			ahb(1'b0, `DBT_OFF_STATUS, 32'h0);
			chk(d[15:0], {y, x}, "isolated capture");
			mode(4'b1011, 1'b0, 8'h00, 1'b0, 8'h00);
			chk({oe_a, oe_b, a_w, b_w}, {2'b11, y, x}, "stored both ways");
			mode(4'b1110, 1'b1, ~x, 1'b0, 8'h00);
			chk({oe_a, oe_b, b_w}, {2'b01, x}, "stored a to b");
			cap(1'b1, 1'b1);
			ahb(1'b0, `DBT_OFF_STATUS, 32'h0);
			chk(d[15:0], {~x, ~x}, "staggered capture");
			mode(4'b1100, 1'b1, ~x, 1'b0, 8'h00);
			chk({oe_a, oe_b, b_w}, {2'b01, ~x}, "live a to b");
			cap(1'b1, 1'b1);
			ahb(1'b0, `DBT_OFF_STATUS, 32'h0);
			chk(d[15:0], {~x, ~x}, "a into both");
			mode(4'b0001, 1'b0, 8'h00, 1'b1, ~y);
			chk({oe_a, oe_b, a_w}, {2'b10, ~x}, "stored b to a");
			mode(4'b0000, 1'b0, 8'h00, 1'b1, ~y);
			chk({oe_a, oe_b, a_w}, {2'b10, ~y}, "live b to a");
			cap(1'b1, 1'b1);
			ahb(1'b0, `DBT_OFF_STATUS, 32'h0);
			chk(d[15:0], {~y, ~y}, "b into both");
			mode(4'b1000, 1'b0, 8'h00, 1'b0, 8'h00);
			repeat (8) @(posedge i_clk);
			#1;
			chk({a_w, b_w}, {~y, ~y}, "bus hold loop");
		end
		// log fill past full, then drain to empty
		ahb(1'b1, `DBT_OFF_CTRL, 32'h24);
		mode(4'b0100, 1'b1, 8'h00, 1'b0, 8'h00);
		for (k = 0; k <= DEPTH; k++) begin
			@(posedge i_clk);
			p_a <= k[7:0];
			cap(1'b1, 1'b0);
		end
		chk({31'h0, log_rdy}, 32'h0, "log refuses when full");
		ahb(1'b0, `DBT_OFF_STATUS, 32'h0);
		chk(d[18:16], 3'b110, "log full with loss");
		ahb(1'b1, `DBT_OFF_STATUS, 32'h0004_0000);
		ahb(1'b0, `DBT_OFF_STATUS, 32'h0);
		chk(d[18:16], 3'b010, "loss flag cleared");
		for (k = 0; k < DEPTH; k++) begin
			ahb(1'b0, `DBT_OFF_LOG, 32'h0);
			chk(d, {1'b1, 22'h0, 1'b0, k[7:0]}, "log entry");
		end
		ahb(1'b0, `DBT_OFF_LOG, 32'h0);
		chk(d, 32'h0, "empty log read");
		ahb(1'b0, `DBT_OFF_STATUS, 32'h0);
		chk({log_rdy, d[18:16]}, 4'b1001, "log drained");
		ahb(1'b1, 8'h0C, 32'hFF);
		ahb(1'b0, 8'h0C, 32'h0);
		chk(d, 32'h0, "unmapped read");
		ahb(1'b0, `DBT_OFF_CTRL, 32'h0);
		chk(d, 32'h24, "control kept");
		// software takes the pins over; a tie on the capture clocks logs a then b
		ahb(1'b1, `DBT_OFF_CTRL, 32'h27);
		cap(1'b1, 1'b1);
		chk({oe_a, oe_b, b_w}, {2'b01, 8'(DEPTH)}, "software override");
		ahb(1'b0, `DBT_OFF_LOG, 32'h0);
		chk(d, {1'b1, 22'h0, 1'b0, 8'(DEPTH)}, "a wins a capture tie");
		ahb(1'b0, `DBT_OFF_LOG, 32'h0);
		chk(d, {1'b1, 22'h0, 1'b1, 8'(DEPTH)}, "b logged one cycle later");
		complete_run;
	end
endmodule : testbench
